// ==== core/reset_sleep_wakeup_control.sv ====
// reset, sleep and wake-up controller with its control registers on classic Wishbone
//
// Behaviour
// - reset on power-up, pin low, watchdog timeout
// - hold reset 18ms, 500ms in low-freq crystal
// - reset loads program counter zero, oscillator runs
// - reset forces every port pin to input
// - reset clears watchdog counter and prescaler
// - power-up alone clears status bits 7..5
// - reset sets three port config registers all-ones
// - reset clears watchdog mask bits 7,5,4
// - reset clears irq flags and irq enables
// - sleep stops oscillator, timers; clears watchdog
// - sleep during conversion keeps oscillator, timers running
// - sleep wakes on pin, watchdog, enabled events
// - pin or watchdog wake resets, flags record source
// - wake with irqs on vectors 06, 0F, 0C
// - wake with irqs off resumes next instruction
// - watchdog on at sleep masks wake enables
// - event wake delay follows oscillator mode
// - conversion wake waits 15 converter clock periods
// - port change without sleep vectors or continues
// - port-change enables sit at bit 1
`timescale 1ns/1ns
module reset_sleep_wakeup_control
    import rswc_pkg::*;
#(
    parameter logic [CNT_W-1:0] RST_HOLD_CYCLES    = CNT_W'(RST_HOLD_CYC),
    parameter logic [CNT_W-1:0] LXT_HOLD_CYCLES    = CNT_W'(LXT_HOLD_CYC),
    parameter logic [CNT_W-1:0] HXT_WAKE_CYCLES    = CNT_W'(HXT_WAKE_CYC),
    parameter logic [CNT_W-1:0] WDT_TIMEOUT_CYCLES = CNT_W'(WDT_TIMEOUT_CYC)
)(
    // clock and power-on reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // pins and analogue events
    input  wire logic        resetPinN,
    input  wire logic [7:0]  port5Pins,
    input  wire logic        cmpOut,
    input  wire logic        convBusy,
    input  wire logic        convDone,
    input  wire logic        convClkTick,
    // processor core
    input  wire logic        sleepInstr,
    input  wire logic        wdtClearInstr,
    input  wire logic        globalIrqOnInstr,
    input  wire logic        globalIrqOffInstr,
    output logic             coreHold,
    output logic             pcLoad,
    output logic      [7:0]  pcVector,
    output logic             resumeNext,
    output logic             oscRun,
    output logic             timersRun,
    output logic             portForceInput
);

    // ****************************************
    // registers
    // ****************************************
    ctl_state_t       state_reg;
    wake_src_t        wakeSrc_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [7:0]       status_reg, wakeCtl_reg, irqFlag_reg, wdMask_reg, irqEn_reg;
    logic [7:0]       pcfgB_reg, pcfgC_reg, pcfgD_reg, port5Latch_reg;
    osc_mode_t        oscMode_reg;
    logic             gie_reg, wdtAtSleep_reg, cmpPrev_reg, ack_reg;
    logic [7:0]       wdtPre_reg;
    logic [CNT_W-1:0] wdtCnt_reg;
    logic [31:0]      dat_reg;
    logic             pcLoad_reg, resume_reg, osc_reg, timers_reg;
    logic [7:0]       pcVec_reg;

    function automatic logic [7:0] ratio_mask(input logic [2:0] sel);
        ratio_mask = 8'((9'h002 << sel) - 9'h001);
    endfunction : ratio_mask

    function automatic logic [7:0] vector_of(input wake_src_t src);
        vector_of = (src == SRC_PORT) ? VEC_PORT : (src == SRC_CMP) ? VEC_CMP : VEC_CONV;
    endfunction : vector_of

    // ****************************************
    // decode
    // ****************************************
    wire        busReq    = cyc_i && stb_i;
    wire        wrNow     = busReq && we_i && ack_reg && sel_i[0];
    wire        rdTake    = busReq && !ack_reg;
    wire [7:0]  wd        = dat_i[7:0];
    wire        wdtEn     = wdMask_reg[WDM_WDT_EN_BIT];
    wire        wdtTick   = !wdMask_reg[WDM_PRE_ON_BIT]
                            || ((wdtPre_reg & ratio_mask(wdMask_reg[2:0])) == ratio_mask(wdMask_reg[2:0]));
    wire        wdtTo     = wdtEn && wdtTick && (wdtCnt_reg == WDT_TIMEOUT_CYCLES - 1'b1);
    wire        pinRst    = !resetPinN;
    wire        extRst    = pinRst || wdtTo;
    // a pin compare against the latch taken at the last read of port 5
    wire        portChg   = port5Pins != port5Latch_reg;
    wire        cmpChg    = cmpOut != cmpPrev_reg;
    wire        portIrq   = portChg && irqEn_reg[IEN_PORT_BIT];
    wire        cmpIrq    = cmpChg && wdMask_reg[WDM_CMP_IE_BIT];
    wire        convIrq   = convDone && wdMask_reg[WDM_CONV_IE_BIT];
    // watchdog on at sleep entry masks every wake enable
    wire        wakeOk    = !wdtAtSleep_reg;
    wire        wakePort  = wakeOk && wakeCtl_reg[WAKE_PORT_BIT] && portChg;
    wire        wakeCmp   = wakeOk && wakeCtl_reg[WAKE_CMP_BIT] && cmpChg;
    wire        wakeConv  = wakeOk && wakeCtl_reg[WAKE_CONV_BIT] && convDone;
    wire        anyWake   = wakePort || wakeCmp || wakeConv;
    wire [CNT_W-1:0] holdLim = (oscMode_reg == OSC_LXT) ? LXT_HOLD_CYCLES : RST_HOLD_CYCLES;
    wire [CNT_W-1:0] wakeLim = (oscMode_reg == OSC_LXT) ? LXT_HOLD_CYCLES :
                               (oscMode_reg == OSC_HXT) ? HXT_WAKE_CYCLES :
                               CNT_W'(WAKE_OSC_CLKS);
    wire        holdDone  = (state_reg == ST_HOLD) && (cnt_reg == holdLim - 1'b1);
    wire        wakeDone  = (state_reg == ST_WAKE) && ((wakeSrc_reg == SRC_CONV)
                            ? (convClkTick && cnt_reg == CNT_W'(CONV_WAKE_TICKS - 1))
                            : (cnt_reg == wakeLim - 1'b1));
    wire        runVec    = (state_reg == ST_RUN) && gie_reg && (portIrq || cmpIrq || convIrq);
    wire        goSleep   = (state_reg == ST_RUN) && sleepInstr && !runVec;
    wire [7:0]  rdMux     = (adr_i == OFS_STATUS)  ? status_reg  :
                            (adr_i == OFS_WAKECTL) ? wakeCtl_reg :
                            (adr_i == OFS_IRQFLAG) ? irqFlag_reg :
                            (adr_i == OFS_WDMASK)  ? wdMask_reg  :
                            (adr_i == OFS_IRQEN)   ? irqEn_reg   :
                            (adr_i == OFS_PCFG_B)  ? pcfgB_reg   :
                            (adr_i == OFS_PCFG_C)  ? pcfgC_reg   :
                            (adr_i == OFS_PCFG_D)  ? pcfgD_reg   :
                            (adr_i == OFS_PORT5)   ? port5Pins   :
                            (adr_i == OFS_OSCMODE) ? {4'h0, state_reg, oscMode_reg} : 8'h00;

    assign ack_o          = ack_reg;
    assign dat_o          = dat_reg;
    assign coreHold       = (state_reg == ST_HOLD);
    assign portForceInput = coreHold;
    assign pcLoad         = pcLoad_reg;
    assign pcVector       = pcVec_reg;
    assign resumeNext     = resume_reg;
    assign oscRun         = osc_reg;
    assign timersRun      = timers_reg;

    // ****************************************
    // wishbone handshake and read data
    // ****************************************
    always_ff @(posedge mclk)
    begin
        ack_reg <= !rst && busReq && !ack_reg;
        if (rst)
            dat_reg <= 32'h0000_0000;
        else if (rdTake)
            dat_reg <= {24'h00_0000, rdMux};
    end

    // reading port 5 re-arms the change detector
    always_ff @(posedge mclk)
    begin
        if (rst)
            port5Latch_reg <= 8'h00;
        else if (rdTake && !we_i && adr_i == OFS_PORT5)
            port5Latch_reg <= port5Pins;
        if (rst)
            cmpPrev_reg <= 1'b0;
        else
            cmpPrev_reg <= cmpOut;
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            status_reg  <= STATUS_RESET & 8'h1F;
            wakeCtl_reg <= REG_CLEAR;
            wdMask_reg  <= REG_CLEAR;
            irqEn_reg   <= REG_CLEAR;
            pcfgB_reg   <= PCFG_RESET;
            pcfgC_reg   <= PCFG_RESET;
            pcfgD_reg   <= PCFG_RESET;
            oscMode_reg <= OSC_RC;
        end
        else if (extRst && state_reg != ST_HOLD)
        begin
            // upper status bits survive pin and watchdog resets
            status_reg[STAT_T_BIT] <= !wdtTo;
            status_reg[STAT_P_BIT] <= (state_reg == ST_RUN);
            wakeCtl_reg <= wakeCtl_reg & WAKE_RST_MASK;
            wdMask_reg  <= wdMask_reg & WDM_RST_MASK;
            irqEn_reg   <= REG_CLEAR;
            pcfgB_reg   <= PCFG_RESET;
            pcfgC_reg   <= PCFG_RESET;
            pcfgD_reg   <= PCFG_RESET;
        end
        else if (wrNow)
        begin
            if (adr_i == OFS_STATUS)
                status_reg <= {wd[7:5], status_reg[4:3], wd[2:0]};
            else if (adr_i == OFS_WAKECTL)
                wakeCtl_reg <= wd;
            else if (adr_i == OFS_WDMASK)
                wdMask_reg <= wd;
            else if (adr_i == OFS_IRQEN)
                irqEn_reg <= wd;
            else if (adr_i == OFS_PCFG_B)
                pcfgB_reg <= wd;
            else if (adr_i == OFS_PCFG_C)
                pcfgC_reg <= wd;
            else if (adr_i == OFS_PCFG_D)
                pcfgD_reg <= wd;
            else if (adr_i == OFS_OSCMODE && wd[1:0] != 2'b11)
                oscMode_reg <= osc_mode_t'(wd[1:0]);
        end
    end

    // flags are write-one-to-clear; a new event in the same cycle wins
    wire [7:0] flagSet = ({7'h00, portIrq} << FLAG_PORT_BIT)
                       | ({7'h00, cmpIrq} << FLAG_CMP_BIT)
                       | ({7'h00, convIrq} << FLAG_CONV_BIT);
    wire [7:0] flagClr = (wrNow && adr_i == OFS_IRQFLAG) ? wd : 8'h00;

    always_ff @(posedge mclk)
    begin
        if (rst || (extRst && state_reg != ST_HOLD))
            irqFlag_reg <= REG_CLEAR;
        else if (state_reg != ST_HOLD)
            irqFlag_reg <= (irqFlag_reg & ~flagClr) | flagSet;
    end

    // ****************************************
    // watchdog; runs on its own oscillator, so also in sleep
    // ****************************************
    always_ff @(posedge mclk)
    begin
        if (rst || extRst || state_reg == ST_HOLD || wdtClearInstr || goSleep)
        begin
            wdtPre_reg <= 8'h00;
            wdtCnt_reg <= '0;
        end
        else if (wdtEn)
        begin
            wdtPre_reg <= wdtPre_reg + 8'h01;
            if (wdtTick)
                wdtCnt_reg <= wdtCnt_reg + 1'b1;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge mclk)
    begin
        pcLoad_reg <= 1'b0;
        resume_reg <= 1'b0;
        if (rst)
        begin
            state_reg      <= ST_HOLD;
            cnt_reg        <= '0;
            wakeSrc_reg    <= SRC_PORT;
            gie_reg        <= 1'b0;
            wdtAtSleep_reg <= 1'b0;
            pcVec_reg      <= VEC_RESET;
            osc_reg        <= 1'b1;
            timers_reg     <= 1'b0;
        end
        else if (extRst && !(state_reg == ST_HOLD && resetPinN))
        begin
            // a reset from any state restarts the hold and the oscillator
            state_reg  <= ST_HOLD;
            cnt_reg    <= '0;
            gie_reg    <= 1'b0;
            osc_reg    <= 1'b1;
            timers_reg <= 1'b0;
        end
        else
        begin
            if (globalIrqOnInstr)
                gie_reg <= 1'b1;
            else if (globalIrqOffInstr)
                gie_reg <= 1'b0;
            case (state_reg)
                ST_HOLD:
                begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (holdDone)
                    begin
                        state_reg  <= ST_RUN;
                        pcLoad_reg <= 1'b1;
                        pcVec_reg  <= VEC_RESET;
                        timers_reg <= 1'b1;
                    end
                end
                ST_RUN:
                begin
                    if (runVec)
                    begin
                        // a pending change outranks a sleep in the same cycle
                        pcLoad_reg <= 1'b1;
                        pcVec_reg  <= portIrq ? VEC_PORT : cmpIrq ? VEC_CMP : VEC_CONV;
                    end
                    else if (sleepInstr)
                    begin
                        state_reg      <= ST_SLEEP;
                        wdtAtSleep_reg <= wdtEn;
                        osc_reg        <= convBusy;
                        timers_reg     <= convBusy;
                    end
                end
                ST_SLEEP:
                begin
                    cnt_reg <= '0;
                    if (anyWake)
                    begin
                        state_reg   <= ST_WAKE;
                        osc_reg     <= 1'b1;
                        wakeSrc_reg <= wakePort ? SRC_PORT : wakeCmp ? SRC_CMP : SRC_CONV;
                    end
                end
                ST_WAKE:
                begin
                    if (wakeSrc_reg != SRC_CONV || convClkTick)
                        cnt_reg <= cnt_reg + 1'b1;
                    if (wakeDone)
                    begin
                        state_reg  <= ST_RUN;
                        timers_reg <= 1'b1;
                        if (gie_reg)
                        begin
                            pcLoad_reg <= 1'b1;
                            pcVec_reg  <= vector_of(wakeSrc_reg);
                        end
                        else
                            resume_reg <= 1'b1;
                    end
                end
                default:
                    state_reg <= ST_HOLD;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_pin_reset;
        @(posedge mclk) disable iff (rst) !resetPinN |=> coreHold && portForceInput;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin low did not hold reset");

    property p_wdt_reset;
        @(posedge mclk) disable iff (rst) wdtTo |=> coreHold && !status_reg[STAT_T_BIT];
    endproperty
    a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog timeout not recorded");

    property p_hold_exit;
        @(posedge mclk) disable iff (rst) $fell(coreHold) |-> pcLoad && pcVector == VEC_RESET && oscRun;
    endproperty
    a_hold_exit: assert property (p_hold_exit) else $error("reset exit without vector zero");

    property p_hold_len;
        @(posedge mclk) disable iff (rst) $fell(coreHold) |-> $past(cnt_reg) == holdLim - 1'b1;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset hold length wrong");

    property p_upper_keep;
        @(posedge mclk) disable iff (rst) !resetPinN |=> status_reg[7:5] == $past(status_reg[7:5]);
    endproperty
    a_upper_keep: assert property (p_upper_keep) else $error("pin reset altered status bits");

    property p_pcfg_set;
        @(posedge mclk) disable iff (rst)
            (extRst && state_reg != ST_HOLD) |=> pcfgB_reg == PCFG_RESET && pcfgC_reg == PCFG_RESET
            && pcfgD_reg == PCFG_RESET && irqEn_reg == REG_CLEAR && wdMask_reg[7] == 1'b0;
    endproperty
    a_pcfg_set: assert property (p_pcfg_set) else $error("reset values not applied");

    property p_sleep_stop;
        @(posedge mclk) disable iff (rst)
            goSleep && !extRst |=> state_reg == ST_SLEEP && oscRun == $past(convBusy) && wdtCnt_reg == '0;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("sleep entry wrong");

    property p_wdt_masks;
        @(posedge mclk) disable iff (rst)
            state_reg == ST_SLEEP && wdtAtSleep_reg && !extRst |=> state_reg != ST_WAKE;
    endproperty
    a_wdt_masks: assert property (p_wdt_masks) else $error("event woke with watchdog on");

    property p_wake_vec;
        @(posedge mclk) disable iff (rst)
            wakeDone && !extRst && gie_reg |=> pcLoad && pcVector == vector_of(wakeSrc_reg);
    endproperty
    a_wake_vec: assert property (p_wake_vec) else $error("wake vector wrong");

    property p_wake_resume;
        @(posedge mclk) disable iff (rst)
            wakeDone && !extRst && !gie_reg |=> resumeNext && !pcLoad;
    endproperty
    a_wake_resume: assert property (p_wake_resume) else $error("wake did not resume");

endmodule : reset_sleep_wakeup_control

// ==== core/rswc_pkg.sv ====
// constants, register map and types for the reset, sleep and wake-up controller
package rswc_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_KHZ         = 25000;
    localparam int RST_HOLD_MS     = 18;
    localparam int LXT_HOLD_MS     = 500;
    localparam int HXT_WAKE_MS     = 2;
    localparam int WAKE_OSC_CLKS   = 32;
    localparam int WDT_TIMEOUT_MS  = 18;
    localparam int CONV_WAKE_TICKS = 15;
    localparam int RST_HOLD_CYC    = RST_HOLD_MS * CLK_KHZ;
    localparam int LXT_HOLD_CYC    = LXT_HOLD_MS * CLK_KHZ;
    localparam int HXT_WAKE_CYC    = HXT_WAKE_MS * CLK_KHZ + WAKE_OSC_CLKS;
    localparam int WDT_TIMEOUT_CYC = WDT_TIMEOUT_MS * CLK_KHZ;
    localparam int CNT_W           = 24;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_WAKECTL  = 8'h04;
    localparam logic [7:0] OFS_IRQFLAG  = 8'h08;
    localparam logic [7:0] OFS_WDMASK   = 8'h0C;
    localparam logic [7:0] OFS_IRQEN    = 8'h10;
    localparam logic [7:0] OFS_PCFG_B   = 8'h14;
    localparam logic [7:0] OFS_PCFG_C   = 8'h18;
    localparam logic [7:0] OFS_PCFG_D   = 8'h1C;
    localparam logic [7:0] OFS_PORT5    = 8'h20;
    localparam logic [7:0] OFS_OSCMODE  = 8'h24;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int STAT_T_BIT       = 4;
    localparam int STAT_P_BIT       = 3;
    localparam int WAKE_PORT_BIT    = 1;
    localparam int WAKE_CMP_BIT     = 2;
    localparam int WAKE_CONV_BIT    = 3;
    localparam int WDM_WDT_EN_BIT   = 7;
    localparam int WDM_CONV_IE_BIT  = 5;
    localparam int WDM_CMP_IE_BIT   = 4;
    localparam int WDM_PRE_ON_BIT   = 3;
    localparam int IEN_PORT_BIT     = 1;
    localparam int FLAG_PORT_BIT    = 1;
    localparam int FLAG_CMP_BIT     = 4;
    localparam int FLAG_CONV_BIT    = 5;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] REG_CLEAR    = 8'h00;
    localparam logic [7:0] PCFG_RESET   = 8'hFF;
    localparam logic [7:0] WDM_RST_MASK = 8'h4F;
    localparam logic [7:0] WAKE_RST_MASK = 8'hCF;

    // ****************************************
    // vectors
    // ****************************************
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [7:0] VEC_PORT  = 8'h06;
    localparam logic [7:0] VEC_CONV  = 8'h0C;
    localparam logic [7:0] VEC_CMP   = 8'h0F;

    typedef enum logic [1:0] {
        OSC_RC  = 2'b00,
        OSC_HXT = 2'b01,
        OSC_LXT = 2'b10
    } osc_mode_t;

    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_RUN   = 2'b01,
        ST_SLEEP = 2'b10,
        ST_WAKE  = 2'b11
    } ctl_state_t;

    typedef enum logic [1:0] {
        SRC_PORT = 2'b00,
        SRC_CMP  = 2'b01,
        SRC_CONV = 2'b10
    } wake_src_t;

endpackage : rswc_pkg

// ==== dv/core_model.sv ====
// processor core stand-in: turns firmware steps into one-cycle instruction pulses
`timescale 1ns/1ns
module core_model (
    // clock
    input  wire logic mclk,
    // instruction pulses
    output logic      sleepInstr,
    output logic      wdtClearInstr,
    output logic      globalIrqOnInstr,
    output logic      globalIrqOffInstr
);
    initial {sleepInstr, wdtClearInstr, globalIrqOnInstr, globalIrqOffInstr} = 4'h0;
    // 0 sleep, 1 watchdog clear, 2 irq on, 3 irq off; one step per call
    task automatic issue(input int k);
        @(posedge mclk);
        {sleepInstr, wdtClearInstr, globalIrqOnInstr, globalIrqOffInstr} <= 4'h8 >> k;
        @(posedge mclk);
        {sleepInstr, wdtClearInstr, globalIrqOnInstr, globalIrqOffInstr} <= 4'h0;
    endtask : issue
endmodule : core_model

// ==== dv/tb_reset_sleep_wakeup_control.sv ====
// self-checking bench for the reset, sleep and wake-up controller
`timescale 1ns/1ns
module tb_reset_sleep_wakeup_control;
    import rswc_pkg::*;
    logic        mclk, rst, cyc, stb, we, resetPinN, convBusy, convDone, evSeen, cmp;
    logic        convClkTick = 1'b0;
    logic        ack, coreHold, pcLoad, resumeNext, oscRun, timersRun, portForceInput;
    logic        sleepI, clrI, onI, offI;
    logic [3:0]  sel;
    logic [7:0]  adr, port5Pins, pcVector;
    logic [31:0] dat, datO, rdat;
    int          n_mismatch, checks, n, i;
    localparam logic [7:0] MSK [10] = '{8'hE0, 8'h30, 8'hFF, 8'hB0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [7:0] EXP [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
    core_model u_core_model (.mclk(mclk), .sleepInstr(sleepI), .wdtClearInstr(clrI),
        .globalIrqOnInstr(onI), .globalIrqOffInstr(offI));
    // short hold and wake counts keep the run brief
    reset_sleep_wakeup_control #(.RST_HOLD_CYCLES(24'h14), .LXT_HOLD_CYCLES(24'h1E),
        .HXT_WAKE_CYCLES(24'h28), .WDT_TIMEOUT_CYCLES(24'h0A)) u_reset_sleep_wakeup_control (
        .mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat), .dat_o(datO), .ack_o(ack), .resetPinN(resetPinN), .port5Pins(port5Pins),
        .cmpOut(cmp), .convBusy(convBusy), .convDone(convDone), .convClkTick(convClkTick),
        .sleepInstr(sleepI), .wdtClearInstr(clrI), .globalIrqOnInstr(onI), .globalIrqOffInstr(offI),
        .coreHold(coreHold), .pcLoad(pcLoad), .pcVector(pcVector), .resumeNext(resumeNext),
        .oscRun(oscRun), .timersRun(timersRun), .portForceInput(portForceInput));
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) convClkTick <= ~convClkTick;
    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic bound(input int c, input int lim);
        if (c >= lim)
        begin
            chk(c, 0);
            tally_and_finish();
        end
    endtask : bound
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int c;
        @(posedge mclk);
        {cyc, stb, we, sel, adr, dat} <= {2'b11, w, 4'hF, a, 24'h0, d};
        for (c = 0; c < 20 && ack !== 1'b1; c++) @(posedge mclk);
        rdat = datO;
        {cyc, stb} <= 2'b00;
        bound(c, 20);
    endtask : wb
    task automatic waitev(output int c);
        for (c = 0; c < 400 && pcLoad !== 1'b1 && resumeNext !== 1'b1; c++) @(posedge mclk);
        bound(c, 400);
    endtask : waitev
    task automatic waithold(input logic lvl, output int c);
        for (c = 0; c < 4000 && coreHold !== lvl; c++)
        begin
            @(posedge mclk);
            evSeen = evSeen | pcLoad | resumeNext;
        end
        bound(c, 4000);
    endtask : waithold
    // watchdog off, re-arm, pick irq state, enable port wake, sleep, invert every pin
    task automatic portwake(input int g);
        wb(1'b1, OFS_WDMASK, 8'h00);
        u_core_model.issue(1);
        wb(1'b0, OFS_PORT5, 8'h00);
        u_core_model.issue(g);
        wb(1'b1, OFS_WAKECTL, 8'h02);
        wb(1'b1, OFS_IRQEN, 8'h02);
        u_core_model.issue(0);
        @(posedge mclk);
        chk({oscRun, timersRun}, 2'b00);
        port5Pins <= ~port5Pins;
        waitev(n);
        chk(n >= 33 && n <= 35, 1'b1);
        // the vector output keeps the last loaded vector, the port one in both runs
        chk({pcLoad, resumeNext, pcVector}, {g == 2 ? 2'b10 : 2'b01, VEC_PORT});
    endtask : portwake
    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        {cyc, stb, we, sel, adr, dat, convBusy, convDone, cmp, evSeen, port5Pins} = '0;
        rst = 1'b1;
        resetPinN = 1'b1;
        repeat (5) @(posedge mclk);
        chk({coreHold, portForceInput, oscRun}, 3'b111);
        rst <= 1'b0;
        waithold(1'b0, n);
        chk(n >= 20 && n <= 22, 1'b1);
        chk({pcLoad, pcVector}, {1'b1, VEC_RESET});
        for (i = 0; i < 10; i++)
        begin
            wb(1'b0, i < 9 ? 8'(i * 4) : 8'h3C, 8'h00);
            chk(rdat & {24'h0, MSK[i]}, {24'h0, EXP[i]});
        end
        $display("end power-on reset");
        wb(1'b1, OFS_STATUS, 8'hE0);
        resetPinN <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(coreHold, 1'b1);
        resetPinN <= 1'b1;
        waithold(1'b0, n);
        wb(1'b0, OFS_STATUS, 8'h00);
        chk(rdat[7:5], 3'h7);
        $display("end pin reset");
        portwake(2);
        portwake(3);
        $display("end port wake");
        wb(1'b0, OFS_PORT5, 8'h00);
        wb(1'b1, OFS_WAKECTL, 8'h02);
        wb(1'b1, OFS_WDMASK, 8'h80);
        u_core_model.issue(0);
        port5Pins <= ~port5Pins;
        evSeen = 1'b0;
        waithold(1'b1, n);
        chk(evSeen, 1'b0);
        waithold(1'b0, n);
        wb(1'b0, OFS_STATUS, 8'h00);
        chk(rdat[STAT_T_BIT], 1'b0);
        $display("end watchdog wake");
        wb(1'b0, OFS_PORT5, 8'h00);
        wb(1'b1, OFS_WAKECTL, 8'h08);
        convBusy <= 1'b1;
        u_core_model.issue(0);
        @(posedge mclk);
        chk({oscRun, timersRun}, 2'b11);
        convDone <= 1'b1;
        @(posedge mclk);
        {convDone, convBusy} <= 2'b00;
        waitev(n);
        chk({resumeNext, n >= 29 && n <= 34}, 2'b11);
        $display("end conversion wake");
        // high-frequency crystal mode, comparator wake with global irq on
        wb(1'b1, OFS_OSCMODE, 8'h01);
        wb(1'b1, OFS_WAKECTL, 8'h04);
        u_core_model.issue(2);
        u_core_model.issue(0);
        @(posedge mclk);
        cmp <= 1'b1;
        waitev(n);
        chk(n >= 41 && n <= 43, 1'b1);
        chk({pcLoad, resumeNext, pcVector}, {2'b10, VEC_CMP});
        $display("end comparator wake");
        tally_and_finish();
    end
endmodule : tb_reset_sleep_wakeup_control
